// File: rtl/csc_top.sv
`timescale 1ns/1ps
`include "csc_cfg.svh"

module csc_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Async reset
   input wire logic ce_i, // Clock enable
   input wire logic in_valid_i, // Push request
   output logic in_ready_o, // Not full
   input wire logic [W-1:0] in_data_i, // Push data
   output logic out_valid_o, // Not empty
   input wire logic out_ready_i, // Pop request
   output logic [W-1:0] out_data_o // Head word
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_q != (AW+1)'(D));
   assign out_valid_o = (cnt_q != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem[rp_q];

   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem[wp_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (ce_i) begin
         if (push) begin
            wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module csc_top
   import csc_pkg::*;
#(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic CLK_I, // 125 MHz clock
   input wire logic SYS_RST_I, // Async reset, active high
   input wire logic CE_I, // Freezes all state when low
   input wire csc_bus_s BUS_I, // Internal register access
   output logic [7:0] BUS_RDATA_O, // Read data, one cycle after rd
   input wire logic TMR2_TICK_I, // Timer two half-period tick
   input wire logic PRESC_TICK_I, // Prescaler half-period tick
   input wire logic CLK_PORT_LATCH_I, // Clock port latch, idle level
   input wire logic SCK_I, // Serial clock pin level
   output csc_pin_s SCK_O, // Serial clock pin drive
   input wire logic SI_I, // Input pin / bus pin zero level
   output csc_pin_s SI_O, // Bus pin zero drive
   input wire logic SO_I, // Output pin / bus pin one level
   output csc_pin_s SO_O, // Output pin / bus pin one drive
   output logic IRQ_FLAG_O, // Channel interrupt request flag
   input wire logic IRQ_ACK_I, // Clears the request flag
   output logic RX_VALID_O, // Received byte available
   input wire logic RX_READY_I, // Received byte taken
   output logic [7:0] RX_DATA_O // Received byte
);
   logic [7:0] mode_q;
   logic [7:0] sva_q;
   logic bsy_bit_q, busy_mode_q, ack_en_q, ack_hold_q;
   logic ack_det_q, start_det_q, stop_det_q;
   logic cause_q, mask_q, clc_q;
   logic [1:0] wait_fld_q;
   logic [7:0] sr_q;
   logic so_q;
   logic xfer_q, sck_int_q, wait_q, sck_prev_q, sda_prev_q, irq_q;
   logic [3:0] cnt_q;
   logic [7:0] rdata_q;
   logic en, three_wire, two_wire, lsb_first, ext_clk, tick, sda_in;
   logic fall, rise, last_rise, done, start, match, fifo_ready;
   logic wr_mode, wr_bc, wr_sr, wr_tm, wr_sva, drive_low, auto_ack;
   logic [3:0] last_cnt;
   logic [7:0] wdata_ord, sr_ord, rd_val, sr_fin, rx_byte;

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction

   assign en = mode_q[`CSC_MODE_ENABLE];
   assign three_wire = ~mode_q[`CSC_MODE_SEL_HI];
   assign two_wire = mode_q[`CSC_MODE_SEL_HI] & mode_q[`CSC_MODE_SEL_MID];
   assign lsb_first = three_wire & mode_q[`CSC_MODE_FIRST_PIN];
   assign ext_clk = ~mode_q[`CSC_MODE_SRC_HI];
   assign tick = mode_q[`CSC_MODE_SRC_LO] ? PRESC_TICK_I : TMR2_TICK_I;
   assign sda_in = (three_wire | mode_q[`CSC_MODE_FIRST_PIN]) ? SI_I : SO_I;

   assign wr_mode = BUS_I.wr && (BUS_I.addr == `CSC_ADDR_MODE);
   assign wr_bc = BUS_I.wr && (BUS_I.addr == `CSC_ADDR_BUSCTL);
   assign wr_sr = BUS_I.wr && (BUS_I.addr == `CSC_ADDR_SHIFT);
   assign wr_tm = BUS_I.wr && (BUS_I.addr == `CSC_ADDR_TIMING);
   assign wr_sva = BUS_I.wr && (BUS_I.addr == `CSC_ADDR_SLAVE);

   // reverse order at the bus only
   assign wdata_ord = lsb_first ? rev8(BUS_I.wdata) : BUS_I.wdata;
   assign sr_ord = lsb_first ? rev8(sr_q) : sr_q;
   // Last bit lands on the same edge as the push
   assign sr_fin = {sr_q[6:0], sda_in};
   assign rx_byte = lsb_first ? rev8(sr_fin) : sr_fin;

   // edges from pin or internal clock
   assign fall = xfer_q & (ext_clk ? (sck_prev_q & ~SCK_I) : (tick & sck_int_q));
   assign rise = xfer_q & (ext_clk ? (~sck_prev_q & SCK_I) : (tick & ~sck_int_q));
   assign last_cnt = (wait_fld_q == CSC_WAIT_NINE) ? `CSC_BITS_WITH_ACK : `CSC_BITS_PER_BYTE;
   assign last_rise = rise & (cnt_q == last_cnt - 4'd1);
   assign done = last_rise;
   // start only when enabled and idle
   assign start = wr_sr & en & ~xfer_q & ~wait_q & (~ext_clk | SCK_I) & fifo_ready;
   assign match = en & (((sr_q ^ sva_q) & (mask_q ? `CSC_ADDR_MASK_ON : `CSC_ALL_ONES)) == '0);
   assign auto_ack = ack_en_q & xfer_q & (cnt_q == `CSC_BITS_PER_BYTE);
   // busy mode floats the data output
   assign drive_low = (~so_q & ~busy_mode_q) | ack_hold_q | auto_ack;

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         mode_q <= `CSC_RST_REG;
         sva_q <= `CSC_RST_REG;
      end else if (CE_I) begin
         if (wr_mode) begin
            mode_q <= BUS_I.wdata & ~(8'h01 << `CSC_MODE_MATCH);
         end
         if (wr_sva) begin
            sva_q <= BUS_I.wdata;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         bsy_bit_q <= 1'b0;
         ack_en_q <= 1'b0;
         cause_q <= 1'b0;
         mask_q <= 1'b0;
         clc_q <= 1'b0;
         wait_fld_q <= CSC_WAIT_NONE;
      end else if (CE_I) begin
         if (wr_bc) begin
            bsy_bit_q <= BUS_I.wdata[`CSC_BC_BUSY];
            ack_en_q <= BUS_I.wdata[`CSC_BC_ACK_EN];
         end
         if (wr_tm) begin
            cause_q <= BUS_I.wdata[`CSC_TM_CAUSE];
            mask_q <= BUS_I.wdata[`CSC_TM_ADDR_MASK];
            clc_q <= BUS_I.wdata[`CSC_TM_CLK_LEVEL];
            wait_fld_q <= BUS_I.wdata[1:0];
         end
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         busy_mode_q <= 1'b0;
      end else if (CE_I) begin
         if (wr_bc) begin
            busy_mode_q <= BUS_I.wdata[`CSC_BC_BUSY];
         end else if (start || (done && mode_q[`CSC_MODE_WAKEUP] && match)) begin
            busy_mode_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         xfer_q <= 1'b0;
         cnt_q <= '0;
         sck_int_q <= 1'b1;
         sck_prev_q <= 1'b1;
      end else if (CE_I) begin
         sck_prev_q <= SCK_I;
         if (!en) begin
            xfer_q <= 1'b0;
            sck_int_q <= 1'b1;
         end else if (start) begin
            xfer_q <= 1'b1;
            cnt_q <= '0;
            sck_int_q <= 1'b1;
         end else if (xfer_q) begin
            if (!ext_clk && tick) begin
               sck_int_q <= ~sck_int_q;
            end
            if (rise) begin
               cnt_q <= cnt_q + 4'd1;
            end
            if (done) begin
               xfer_q <= 1'b0;
            end
         end
      end
   end

   // sample on rise, plain register when idle
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         sr_q <= `CSC_RST_REG;
      end else if (CE_I) begin
         if (wr_sr && !xfer_q) begin
            sr_q <= wdata_ord;
         end else if (rise && cnt_q < `CSC_BITS_PER_BYTE) begin
            sr_q <= {sr_q[6:0], sda_in};
         end
      end
   end

   // latch forced by triggers, shifted on fall
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         so_q <= 1'b1;
      end else if (CE_I) begin
         if (wr_bc && en && BUS_I.wdata[`CSC_BC_REL_TRIG]) begin
            so_q <= 1'b1;
         end else if (wr_bc && en && BUS_I.wdata[`CSC_BC_CMD_TRIG]) begin
            so_q <= 1'b0;
         end else if (fall && cnt_q < `CSC_BITS_PER_BYTE) begin
            so_q <= sr_q[7];
         end
      end
   end

   // software acknowledge held to next fall
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ack_hold_q <= 1'b0;
         ack_det_q <= 1'b0;
      end else if (CE_I) begin
         if (!en || start || fall) begin
            ack_hold_q <= 1'b0;
         end else if (wr_bc && BUS_I.wdata[`CSC_BC_ACK_TRIG]) begin
            ack_hold_q <= 1'b1;
         end
         if (!en || start) begin
            ack_det_q <= 1'b0;
         end else if (rise && cnt_q == `CSC_BITS_PER_BYTE && !sda_in) begin
            ack_det_q <= 1'b1;
         end
      end
   end

   // stop detection as an extra cause
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         sda_prev_q <= 1'b1;
         start_det_q <= 1'b0;
         stop_det_q <= 1'b0;
      end else if (CE_I) begin
         sda_prev_q <= sda_in;
         if (!en || !two_wire) begin
            start_det_q <= 1'b0;
            stop_det_q <= 1'b0;
         end else if (SCK_I && sck_prev_q && sda_prev_q && !sda_in) begin
            start_det_q <= 1'b1;
            stop_det_q <= 1'b0;
         end else if (SCK_I && sck_prev_q && !sda_prev_q && sda_in) begin
            stop_det_q <= 1'b1;
            start_det_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         wait_q <= 1'b0;
      end else if (CE_I) begin
         if (done && wait_fld_q[1]) begin
            wait_q <= 1'b1;
         end else if (!en || (wr_tm && BUS_I.wdata[`CSC_TM_WAIT_REL])) begin
            wait_q <= 1'b0;
         end
      end
   end

   // interrupt at last rising edge, set beats clear
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         irq_q <= 1'b0;
      end else if (CE_I) begin
         if ((done && (!mode_q[`CSC_MODE_WAKEUP] || match)) ||
             (cause_q && two_wire && SCK_I && sck_prev_q && !sda_prev_q && sda_in)) begin
            irq_q <= 1'b1;
         end else if (IRQ_ACK_I) begin
            irq_q <= 1'b0;
         end
      end
   end

   // A shift register write starts no transfer while the receive buffer is full
   csc_fifo #(
      .W(8),
      .D(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .ce_i(CE_I),
      .in_valid_i(done),
      .in_ready_o(fifo_ready),
      .in_data_i(rx_byte),
      .out_valid_o(RX_VALID_O),
      .out_ready_i(RX_READY_I),
      .out_data_o(RX_DATA_O)
   );

   // triggers and release read as zero
   always_comb begin
      rd_val = '0;
      if (BUS_I.addr == `CSC_ADDR_MODE) begin
         rd_val = mode_q | ({7'b0, match} << `CSC_MODE_MATCH);
      end else if (BUS_I.addr == `CSC_ADDR_BUSCTL) begin
         rd_val = {bsy_bit_q, ack_det_q, ack_en_q, 1'b0, start_det_q, stop_det_q, 2'b00};
      end else if (BUS_I.addr == `CSC_ADDR_SHIFT) begin
         rd_val = sr_ord;
      end else if (BUS_I.addr == `CSC_ADDR_TIMING) begin
         rd_val = {1'b0, en & SCK_I, cause_q, mask_q, clc_q, 1'b0, wait_fld_q};
      end else if (BUS_I.addr == `CSC_ADDR_SLAVE) begin
         rd_val = sva_q;
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rdata_q <= '0;
      end else if (CE_I && BUS_I.rd) begin
         rdata_q <= rd_val;
      end
   end

   assign BUS_RDATA_O = rdata_q;
   assign IRQ_FLAG_O = irq_q;

   // pins given back to ports when disabled
   always_comb begin
      SCK_O = '{o: 1'b0, oe: 1'b0};
      SI_O = '{o: 1'b0, oe: 1'b0};
      SO_O = '{o: 1'b0, oe: 1'b0};
      if (en && three_wire) begin
         SCK_O.o = xfer_q ? sck_int_q : CLK_PORT_LATCH_I;
         SCK_O.oe = ~ext_clk;
         SO_O.o = so_q;
         SO_O.oe = 1'b1;
      end else if (en && two_wire) begin
         SCK_O.oe = (~ext_clk & xfer_q & ~sck_int_q) | wait_q | (~xfer_q & ~clc_q);
         if (mode_q[`CSC_MODE_FIRST_PIN]) begin
            SI_O.oe = drive_low;
         end else begin
            SO_O.oe = drive_low;
         end
      end
   end
endmodule

// File: rtl/csc_cfg.svh
// Summary of operation
// - Busy bit floats data output; transfer ends busy
// - Field 00: interrupt 8th rise, no wait hold
// - Field 10: interrupt 8th rise, hold low
// - Field 11: interrupt 9th rise, hold low
// - Wait release ends wait, reads back zero
// - Idle clock low, or released by level bit
// - Mask bit drops address bit 0 from compare
// - Cause bit adds stop detection to interrupt
// - Pin-level bit mirrors clock pin, zero disabled
// - Disabled: no shifting, plain register, port pins
// - Source field picks pin, timer or prescaler
// - Mode bit 2 picks MSB or LSB first in 3-wire mode
// - Bit order reversed at bus, not shifting
// - Shift on falling edge, sample on rising
// - Eight bits done (nine with field 11): stop; flag set unless wake-up bit is on and address does not match
// - Triggers set/clear latch, self-clear, clear disabled
// - Write starts transfer only when ready and enabled
// - 2-wire uses clock plus one chosen data pin
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
`define CSC_ADDR_MODE 16'hff60
`define CSC_ADDR_BUSCTL 16'hff61
`define CSC_ADDR_SHIFT 16'hff62
`define CSC_ADDR_TIMING 16'hff63
`define CSC_ADDR_SLAVE 16'hff65
`define CSC_RST_REG 8'h00
`define CSC_ALL_ONES 8'hff
`define CSC_ADDR_MASK_ON 8'hfe
`define CSC_BITS_PER_BYTE 4'd8
`define CSC_BITS_WITH_ACK 4'd9
`define CSC_MODE_ENABLE 7
`define CSC_MODE_MATCH 6
`define CSC_MODE_WAKEUP 5
`define CSC_MODE_SEL_HI 4
`define CSC_MODE_SEL_MID 3
`define CSC_MODE_FIRST_PIN 2
`define CSC_MODE_SRC_HI 1
`define CSC_MODE_SRC_LO 0
`define CSC_BC_BUSY 7
`define CSC_BC_ACK_DET 6
`define CSC_BC_ACK_EN 5
`define CSC_BC_ACK_TRIG 4
`define CSC_BC_START_DET 3
`define CSC_BC_STOP_DET 2
`define CSC_BC_CMD_TRIG 1
`define CSC_BC_REL_TRIG 0
`define CSC_TM_PIN_LEVEL 6
`define CSC_TM_CAUSE 5
`define CSC_TM_ADDR_MASK 4
`define CSC_TM_CLK_LEVEL 3
`define CSC_TM_WAIT_REL 2
`endif

// File: rtl/csc_pkg.sv
package csc_pkg;
   typedef enum logic [1:0] {
      CSC_WAIT_NONE = 2'b00,
      CSC_WAIT_BAD = 2'b01,
      CSC_WAIT_EIGHT = 2'b10,
      CSC_WAIT_NINE = 2'b11
   } csc_wait_e;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } csc_bus_s;
   typedef struct packed {
      logic o;
      logic oe;
   } csc_pin_s;
endpackage

// File: tb/csc_top_sva.sv
`timescale 1ns/1ps
module csc_top_sva
   import csc_pkg::*;
(
   input wire logic CLK_I, // Clock
   input wire logic SYS_RST_I, // Reset
   input wire csc_bus_s BUS_I, // Register bus
   input wire logic [7:0] BUS_RDATA_O, // Read data
   input wire logic SCK_I, // Clock pin
   input wire csc_pin_s SCK_O, // Clock drive
   input wire csc_pin_s SI_O, // Pin zero drive
   input wire csc_pin_s SO_O, // Pin one drive
   input wire logic IRQ_FLAG_O, // Request flag
   input wire logic RX_VALID_O, // Byte ready
   input wire logic RX_READY_I, // Byte taken
   input wire logic [7:0] RX_DATA_O // Byte
);
   logic [7:0] mode_q;
   logic [3:0] rise_q;
   logic sck_q;
   logic fell_q;
   wire rd_tm = BUS_I.rd && BUS_I.addr == 16'hff63;
   wire wr_bc = BUS_I.wr && BUS_I.addr == 16'hff61 && mode_q[7];
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // Mode mirror, so rules can be tied to the enable bit
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         mode_q <= 8'h00;
      end else if (BUS_I.wr && BUS_I.addr == 16'hff60) begin
         mode_q <= BUS_I.wdata;
      end
   end
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         sck_q <= 1'b1;
         fell_q <= 1'b0;
         rise_q <= 4'h0;
      end else begin
         sck_q <= SCK_O.o;
         fell_q <= sck_q && !SCK_O.o;
         if (BUS_I.wr && BUS_I.addr == 16'hff62) begin
            rise_q <= 4'h0;
         end else if (!sck_q && SCK_O.o) begin
            rise_q <= rise_q + 4'h1;
         end
      end
   end
   AST_OFF_NO_DRIVE: assert property (!mode_q[7] |-> !SCK_O.oe && !SI_O.oe && !SO_O.oe)
      else $error("pin driven while channel off");
   AST_TRIG_READ_ZERO: assert property (BUS_I.rd && BUS_I.addr == 16'hff61 |=>
      BUS_RDATA_O[1:0] == 2'b00 && !BUS_RDATA_O[4]) else $error("trigger bit read as one");
   AST_PIN_OFF: assert property (rd_tm && !mode_q[7] |=> !BUS_RDATA_O[6] && !BUS_RDATA_O[7])
      else $error("pin level nonzero while off");
   AST_PIN_ON: assert property (rd_tm && mode_q[7] && $stable(SCK_I) && $past(SCK_I, 2) == SCK_I
      |=> BUS_RDATA_O[6] == $past(SCK_I)) else $error("pin level wrong");
   AST_CMD_TRIG: assert property (wr_bc && BUS_I.wdata[1:0] == 2'b10 |=> !SO_O.o)
      else $error("command trigger left latch high");
   AST_REL_TRIG: assert property (wr_bc && BUS_I.wdata[1:0] == 2'b01 |=> SO_O.o)
      else $error("release trigger left latch low");
   AST_MODE_READ: assert property (BUS_I.rd && BUS_I.addr == 16'hff60 |=>
      (BUS_RDATA_O & 8'hbf) == ($past(mode_q) & 8'hbf)) else $error("mode read wrong");
   AST_IRQ_EIGHT: assert property ($rose(IRQ_FLAG_O) && mode_q[7] |->
      rise_q == 4'd7 && !sck_q && SCK_O.o)
      else $error("flag not at eighth rise");
   AST_SO_ON_FALL: assert property (mode_q[7] && $changed(SO_O.o) && !$past(BUS_I.wr)
      |-> $fell(SCK_O.o) || fell_q) else $error("data out moved off a falling clock");
   AST_RX_HOLD: assert property (RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_DATA_O))
      else $error("received byte dropped");
   cover property ($rose(IRQ_FLAG_O));
   cover property (RX_VALID_O && !RX_READY_I ##1 RX_VALID_O);
   cover property (rd_tm && mode_q[7]);
endmodule

bind csc_top csc_top_sva u_sva (.CLK_I, .SYS_RST_I, .BUS_I, .BUS_RDATA_O, .SCK_I, .SCK_O,
   .SI_O, .SO_O, .IRQ_FLAG_O, .RX_VALID_O, .RX_READY_I, .RX_DATA_O);

// File: tb/csc_periph_model.sv
`timescale 1ns/1ps
module csc_periph_model (
   input wire logic rst_i, // Reset
   input wire logic sck_i, // Serial clock pin
   input wire logic so_i, // Data from the channel
   input wire logic [7:0] tx_i, // Byte to send
   output logic si_o, // Data to the channel
   output logic [7:0] rx_o // Byte received
);
   logic [7:0] sh = 8'h00;
   logic [2:0] n;
   initial si_o = 1'b0;
   initial rx_o = 8'h00;
   always @(negedge sck_i) begin
      if (n == 3'd0) sh = tx_i;
      si_o <= sh[7];
      sh = {sh[6:0], 1'b0};
   end
   always @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         n <= 3'd0;
      end else begin
         rx_o <= {rx_o[6:0], so_i};
         n <= n + 3'd1;
      end
   end
endmodule

// File: tb/clocked_serial_channel_zero_test.sv
`timescale 1ns/1ps
module clocked_serial_channel_zero_test;
   import csc_pkg::*;
   logic CLK_I = 1'b0;
   logic SYS_RST_I = 1'b1;
   csc_bus_s BUS_I = '0;
   logic TMR2_TICK_I = 1'b0;
   logic PRESC_TICK_I = 1'b0;
   logic IRQ_ACK_I = 1'b0;
   logic RX_READY_I = 1'b0;
   logic [7:0] BUS_RDATA_O, RX_DATA_O, pm_rx;
   logic [7:0] pm_tx = 8'h00;
   logic IRQ_FLAG_O, RX_VALID_O, si_pin, sck_pin, so_pin;
   logic rd_p = 1'b0;
   csc_pin_s SCK_O, SI_O, SO_O;
   logic [8:0] rdq[$];
   logic [8:0] rxq[$];
   logic [31:0] seed = 32'h5542dc1a;
   int n_fail = 0;
   int n_checks = 0;
   int tc = 0;
   // Pull-ups on released lines
   assign sck_pin = SCK_O.oe ? SCK_O.o : 1'b1;
   assign so_pin = SO_O.oe ? SO_O.o : 1'b1;
   always #4 CLK_I = ~CLK_I;
   csc_top #(.FIFO_DEPTH(4)) DUT (.CLK_I, .SYS_RST_I, .CE_I(1'b1), .BUS_I, .BUS_RDATA_O,
      .TMR2_TICK_I, .PRESC_TICK_I, .CLK_PORT_LATCH_I(1'b1), .SCK_I(sck_pin), .SCK_O,
      .SI_I(si_pin), .SI_O, .SO_I(so_pin), .SO_O, .IRQ_FLAG_O, .IRQ_ACK_I, .RX_VALID_O,
      .RX_READY_I, .RX_DATA_O);
   csc_periph_model u_pm (.rst_i(SYS_RST_I), .sck_i(sck_pin), .so_i(so_pin), .tx_i(pm_tx),
      .si_o(si_pin), .rx_o(pm_rx));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] rev(input logic [7:0] v);
      return {<<{v}};
   endfunction
   task automatic check(input logic [7:0] g, input logic [8:0] e);
      if (!e[8]) begin
         n_checks++;
         if (g !== e[7:0]) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e[7:0]);
         end
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      check({7'h00, g}, {8'h00, e});
   endtask
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
      BUS_I.wr = w;
      BUS_I.rd = !w;
      BUS_I.addr = a;
      BUS_I.wdata = d;
      @(negedge CLK_I);
      BUS_I.wr = 1'b0;
      BUS_I.rd = 1'b0;
      @(negedge CLK_I);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      rdq.push_back({1'b0, e});
      bus(1'b0, a, 8'h00);
   endtask
   // Receive buffer shows the bus view of the byte
   task automatic xfer(input logic lsb);
      logic [7:0] t;
      int k;
      seed = xs(seed);
      t = seed[7:0];
      pm_tx = seed[15:8];
      rxq.push_back({1'b0, lsb ? rev(seed[15:8]) : seed[15:8]});
      wr(16'hff62, t);
      k = 0;
      while (IRQ_FLAG_O !== 1'b1 && k < 1000) begin
         @(negedge CLK_I);
         k++;
      end
      chk1(IRQ_FLAG_O, 1'b1);
      check(pm_rx, {1'b0, lsb ? rev(t) : t});
      if (lsb) rd(16'hff62, rev(pm_tx));
      IRQ_ACK_I = 1'b1;
      @(negedge CLK_I);
      IRQ_ACK_I = 1'b0;
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(negedge CLK_I) begin
      tc <= tc + 1;
      TMR2_TICK_I <= (tc % 4 == 0);
      PRESC_TICK_I <= (tc % 6 == 0);
   end
   always @(posedge CLK_I) begin
      if (rd_p) check(BUS_RDATA_O, rdq.pop_front());
      rd_p = BUS_I.rd;
      if (RX_VALID_O === 1'b1 && RX_READY_I) check(RX_DATA_O, rxq.pop_front());
   end
   initial begin
      #200000;
      n_fail++;
      final_report;
   end
   initial begin
      repeat (16) @(negedge CLK_I);
      SYS_RST_I = 1'b0;
      @(negedge CLK_I);
      rd(16'hff60, 8'h00);
      rd(16'hff61, 8'h00);
      rd(16'hff63, 8'h00);
      rd(16'hff64, 8'h00);
      wr(16'hff62, 8'h5a);
      rd(16'hff62, 8'h5a);
      wr(16'hff61, 8'h02);
      rd(16'hff61, 8'h00);
      wr(16'hff60, 8'h83);
      repeat (60) @(negedge CLK_I);
      chk1(IRQ_FLAG_O, 1'b0);
      wr(16'hff61, 8'h02);
      chk1(SO_O.o, 1'b0);
      rd(16'hff61, 8'h00);
      wr(16'hff61, 8'h01);
      chk1(SO_O.o, 1'b1);
      wr(16'hff63, 8'h34);
      rd(16'hff63, 8'h70);
      wr(16'hff63, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(16'hff60, i[0] ? 8'h82 : 8'h83);
         xfer(1'b0);
      end
      wr(16'hff62, 8'h3c);
      repeat (300) @(negedge CLK_I);
      chk1(IRQ_FLAG_O, 1'b0);
      RX_READY_I = 1'b1;
      repeat (8) @(negedge CLK_I);
      chk1(RX_VALID_O, 1'b0);
      wr(16'hff60, 8'h87);
      xfer(1'b1);
      wr(16'hff60, 8'h00);
      rd(16'hff63, 8'h00);
      repeat (4) @(negedge CLK_I);
      final_report;
   end
endmodule
